// File: rtl/lsspc_consts.svh
// constants for the led sink serial pwm core
`ifndef LSSPC_CONSTS_SVH
`define LSSPC_CONSTS_SVH
`define LSSPC_CHANNELS 16
`define LSSPC_BRIGHT_BITS 12
`define LSSPC_CORR_BITS 7
`define LSSPC_BRIGHT_RESET 12'h000
`define LSSPC_CORR_RESET 7'h00
`define LSSPC_COUNT_RESET 12'h000
`define LSSPC_SYNC_STAGES 3
`endif

// File: rtl/lsspc_pkg.sv
// types for the led sink serial pwm core
package lsspc_pkg;
   typedef enum logic [1:0]
   {
      LSSPC_PWM_IDLE = 2'b01,
      LSSPC_PWM_RUN = 2'b10
   } lsspc_pwm_state_t;
endpackage

// File: rtl/lsspc_pin_sync.sv
// three-stage pin synchroniser with edge detection
`timescale 1ns/10ps
module lsspc_pin_sync
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic pin,
   output logic level,
   output logic rise
);
   logic s1;
   logic s2;
   logic s3;

   // ------------------------------------------------
   // synchroniser chain
   // ------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end
      else
      begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // ------------------------------------------------
   // accepted level: a change counts once stages two and three agree
   // ------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         level <= 1'h0;
      end
      else if (s2 == s3)
      begin
         level <= s3;
      end
   end

   assign rise = s2 & s3 & ~level;
endmodule

// File: rtl/lsspc_core.sv
// led sink serial pwm core: serial ports, latches and pwm outputs
`timescale 1ns/10ps
`include "lsspc_consts.svh"
// Operation
// R1 - brightness clock rise shifts input into lsb
// R2 - brightness msb drives daisy-chain output
// R3 - brightness clock also clocks pwm timing
// R4 - blank low: counter increments per brightness clock rise
// R5 - brightness latch rise copies shift register
// R6 - correction clock rise shifts input into lsb
// R7 - correction msb drives daisy-chain output
// R8 - correction latch rise copies shift register
// R9 - blank high forces all channel outputs off
// R10 - blank high holds counter at zero
// R11 - blank high resets pwm timing state
// R12 - blank low: pwm alone drives outputs
// R13 - host drives two independent serial ports
// R14 - output on while counter below value
// R15 - correction value sets per-channel current level
module lsspc_core
#(
   parameter int CHANNELS = `LSSPC_CHANNELS,
   parameter int BRIGHT_BITS = `LSSPC_BRIGHT_BITS,
   parameter int CORR_BITS = `LSSPC_CORR_BITS
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic bright_serial_in,
   input wire logic bright_shift_clk,
   input wire logic bright_latch_strobe,
   input wire logic corr_serial_in,
   input wire logic corr_shift_clk,
   input wire logic corr_latch_strobe,
   input wire logic blank,
   output logic bright_serial_out,
   output logic corr_serial_out,
   output logic [CHANNELS-1:0] sink_output,
   output logic [CHANNELS*CORR_BITS-1:0] sink_level
);
   localparam int BSR = CHANNELS * BRIGHT_BITS;
   localparam int CSR = CHANNELS * CORR_BITS;

   // ------------------------------------------------
   // parameter checks
   // ------------------------------------------------
   if (CHANNELS < 1 || BRIGHT_BITS < 1 || CORR_BITS < 1)
   begin : g_bad_params
      $error("lsspc_core: widths must be positive");
   end

   if (CHANNELS * BRIGHT_BITS < 2 || CHANNELS * CORR_BITS < 2)
   begin : g_short_shift
      $error("lsspc_core: shift registers need at least two bits");
   end

   // ------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------
   logic bclk_rise;
   logic bin_lvl;
   logic blat_rise;
   logic cclk_rise;
   logic cin_lvl;
   logic clat_rise;
   logic blank_lvl;

   lsspc_pin_sync u_bclk
   (
      .clk(clk),
      .nrst(nrst),
      .pin(bright_shift_clk),
      .level(),
      .rise(bclk_rise)
   );

   lsspc_pin_sync u_bin
   (
      .clk(clk),
      .nrst(nrst),
      .pin(bright_serial_in),
      .level(bin_lvl),
      .rise()
   );

   lsspc_pin_sync u_blat
   (
      .clk(clk),
      .nrst(nrst),
      .pin(bright_latch_strobe),
      .level(),
      .rise(blat_rise)
   );

   lsspc_pin_sync u_cclk
   (
      .clk(clk),
      .nrst(nrst),
      .pin(corr_shift_clk),
      .level(),
      .rise(cclk_rise)
   );

   lsspc_pin_sync u_cin
   (
      .clk(clk),
      .nrst(nrst),
      .pin(corr_serial_in),
      .level(cin_lvl),
      .rise()
   );

   lsspc_pin_sync u_clat
   (
      .clk(clk),
      .nrst(nrst),
      .pin(corr_latch_strobe),
      .level(),
      .rise(clat_rise)
   );

   lsspc_pin_sync u_blank
   (
      .clk(clk),
      .nrst(nrst),
      .pin(blank),
      .level(blank_lvl),
      .rise()
   );

   // ------------------------------------------------
   // shift registers, latches and pwm state
   // ------------------------------------------------
   logic [BSR-1:0] bright_shift;
   logic [BSR-1:0] bright_hold;
   logic [CSR-1:0] corr_shift;
   logic [CSR-1:0] corr_hold;
   logic [BRIGHT_BITS-1:0] pwm_count;
   lsspc_pkg::lsspc_pwm_state_t pwm_state;
   wire logic [CHANNELS-1:0] chan_on;

   // ------------------------------------------------
   // brightness serial port
   // ------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         bright_shift <= {CHANNELS{BRIGHT_BITS'(`LSSPC_BRIGHT_RESET)}};
      end
      else if (bclk_rise)
      begin
         bright_shift <= {bright_shift[BSR-2:0], bin_lvl}; // [R1]
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         bright_serial_out <= 1'b0;
      end
      else if (bclk_rise)
      begin
         bright_serial_out <= bright_shift[BSR-1]; // [R2]
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         bright_hold <= {CHANNELS{BRIGHT_BITS'(`LSSPC_BRIGHT_RESET)}};
      end
      else if (blat_rise)
      begin
         bright_hold <= bright_shift; // [R5]
      end
   end

   // ------------------------------------------------
   // correction serial port
   // ------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         corr_shift <= {CHANNELS{CORR_BITS'(`LSSPC_CORR_RESET)}};
      end
      else if (cclk_rise)
      begin
         corr_shift <= {corr_shift[CSR-2:0], cin_lvl}; // [R6] [R13]
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         corr_serial_out <= 1'b0;
      end
      else if (cclk_rise)
      begin
         corr_serial_out <= corr_shift[CSR-1]; // [R7]
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         corr_hold <= {CHANNELS{CORR_BITS'(`LSSPC_CORR_RESET)}};
      end
      else if (clat_rise)
      begin
         corr_hold <= corr_shift; // [R8]
      end
   end

   // ------------------------------------------------
   // pwm timing
   // ------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         pwm_state <= lsspc_pkg::LSSPC_PWM_IDLE;
      end
      else if (blank_lvl)
      begin
         pwm_state <= lsspc_pkg::LSSPC_PWM_IDLE; // [R11]
      end
      else if (bclk_rise)
      begin
         case (pwm_state)
            lsspc_pkg::LSSPC_PWM_IDLE: pwm_state <= lsspc_pkg::LSSPC_PWM_RUN;
            lsspc_pkg::LSSPC_PWM_RUN: pwm_state <= lsspc_pkg::LSSPC_PWM_RUN;
            default: pwm_state <= lsspc_pkg::LSSPC_PWM_IDLE;
         endcase
      end
   end

   // ------------------------------------------------
   // pwm counter
   // ------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         pwm_count <= BRIGHT_BITS'(`LSSPC_COUNT_RESET);
      end
      else if (blank_lvl)
      begin
         pwm_count <= '0; // [R10]
      end
      else if (bclk_rise)
      begin
         pwm_count <= pwm_count + 1'b1; // [R3] [R4]
      end
   end

   // ------------------------------------------------
   // channel outputs
   // ------------------------------------------------
   function automatic logic chan_lit(input logic [BRIGHT_BITS-1:0] count,
      input logic [BRIGHT_BITS-1:0] value);
      return count < value; // [R14]
   endfunction

   for (genvar ch = 0; ch < CHANNELS; ch++)
   begin : g_chan
      assign chan_on[ch] = (pwm_state == lsspc_pkg::LSSPC_PWM_RUN) && // [R12]
         chan_lit(pwm_count, bright_hold[ch*BRIGHT_BITS +: BRIGHT_BITS]); // [R14]
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         sink_output <= '0;
      end
      else if (blank_lvl)
      begin
         sink_output <= '0; // [R9]
      end
      else
      begin
         sink_output <= chan_on; // [R12]
      end
   end

   // ------------------------------------------------
   // current levels
   // ------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         sink_level <= '0;
      end
      else
      begin
         sink_level <= corr_hold; // [R15]
      end
   end
endmodule

// File: dv/lsspc_core_properties.sv
// port assertions for the led sink core
`timescale 1ns/10ps
module lsspc_core_properties
#(
   parameter int CHANNELS = 16,
   parameter int CORR_BITS = 7
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic bright_shift_clk,
   input wire logic bright_latch_strobe,
   input wire logic corr_shift_clk,
   input wire logic corr_latch_strobe,
   input wire logic blank,
   input wire logic bright_serial_out,
   input wire logic corr_serial_out,
   input wire logic [CHANNELS-1:0] sink_output,
   input wire logic [CHANNELS*CORR_BITS-1:0] sink_level
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   a_blank_off: assert property (blank [*8] |-> sink_output == '0)
      else $error("lit in blank");
   a_dark_start: assert property (blank [*8] ##1 (!blank && !bright_shift_clk) [*8] |->
      sink_output == '0) else $error("lit too soon");
   a_out_cause: assert property ($changed(sink_output) |-> $past(bright_shift_clk, 4)
      || $past(bright_latch_strobe, 4) || $past(blank, 4)) else $error("output moved");
   a_bright_chain: assert property ($changed(bright_serial_out) |->
      $past(bright_shift_clk, 3) || $past(bright_shift_clk, 4)) else $error("bright out");
   a_corr_chain: assert property ($changed(corr_serial_out) |->
      $past(corr_shift_clk, 3) || $past(corr_shift_clk, 4)) else $error("corr out");
   a_bright_quiet: assert property (!bright_shift_clk [*8] |=> $stable(bright_serial_out))
      else $error("bright shift");
   a_corr_quiet: assert property (!corr_shift_clk [*8] |=> $stable(corr_serial_out))
      else $error("corr shift");
   a_level_latch: assert property ($changed(sink_level) |-> $past(corr_latch_strobe, 4))
      else $error("level moved");
   c_lit: cover property ($rose(sink_output[15]));
   c_level: cover property ($changed(sink_level));
   c_blank: cover property ($rose(blank));
endmodule

// File: dv/lsspc_host.sv
// host model for one serial port
`timescale 1ns/10ps
module lsspc_host
(
   input wire logic clk,
   output logic sin,
   output logic sclk,
   output logic lat
);
   initial {sin, sclk, lat} = 3'h0;
   // msb first, 160 ns clock, idle low, data inverted after frame
   task automatic send(input logic [191:0] v, input int n);
      for (int i = n - 1; i >= 0; i--)
      begin
         repeat (10) @(negedge clk);
         sin = v[i];
         repeat (10) @(negedge clk);
         sclk = 1'h1;
         repeat (20) @(negedge clk);
         sclk = 1'h0;
      end
      sin = ~sin;
   endtask
   task automatic latch();
      repeat (20) @(negedge clk) lat = 1'b1;
      repeat (20) @(negedge clk) lat = 1'b0;
   endtask
endmodule

// File: dv/testbench.sv
// self-checking bench for the led sink core
`timescale 1ns/10ps
module testbench;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic blank = 1'b1;
   logic bi, bc, bl, ci, cc, cl, bo, co;
   logic [15:0] so;
   logic [111:0] sl;
   logic [191:0] d;
   int n_mismatch = 0;
   int checks = 0;
   int cyc = 0;
   always #2 clk = ~clk;
   lsspc_host u_hb (.clk(clk), .sin(bi), .sclk(bc), .lat(bl));
   lsspc_host u_hc (.clk(clk), .sin(ci), .sclk(cc), .lat(cl));
   lsspc_core u_lsspc_core (.clk(clk), .nrst(nrst), .bright_serial_in(bi),
      .bright_shift_clk(bc), .bright_latch_strobe(bl), .corr_serial_in(ci),
      .corr_shift_clk(cc), .corr_latch_strobe(cl), .blank(blank), .bright_serial_out(bo),
      .corr_serial_out(co), .sink_output(so), .sink_level(sl));
   task automatic cmp_bit(input string nm, input logic e, input logic g);
      checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmp_out(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmp_lvl(input string nm, input logic [111:0] e, input logic [111:0] g);
      checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic test_corr();
      for (int n = 0; n < 16; n++)
         d[n*7+:7] = 7'(n * 9 + 3);
      u_hc.send(d, 112);
      u_hc.latch();
      cmp_lvl("sink_level", d[111:0], sl);
      for (int k = 0; k < 3; k++)
      begin
         u_hc.send('0, 1);
         cmp_bit("corr_serial_out", d[111-k], co);
      end
      $display("corr done");
   endtask
   task automatic test_bright();
      logic [15:0] m;
      for (int n = 0; n < 16; n++)
         d[n*12+:12] = 12'(n);
      u_hb.send(d, 192);
      u_hb.latch();
      @(negedge clk) blank = 1'b0;
      for (int k = 1; k < 17; k++)
      begin
         u_hb.send('0, 1);
         for (int n = 0; n < 16; n++)
            m[n] = k < n;
         cmp_out("sink_output", m, so);
         cmp_bit("bright_serial_out", d[192-k], bo);
      end
      $display("bright done");
   endtask
   task automatic test_blank();
      @(negedge clk) blank = 1'b1;
      u_hb.send('0, 1);
      cmp_out("sink_output", '0, so);
      @(negedge clk) blank = 1'b0;
      u_hb.send('0, 1);
      cmp_out("sink_output", 16'hfffc, so);
      @(negedge clk) blank = 1'b1;
      repeat (8) @(negedge clk);
      cmp_out("sink_output", '0, so);
      $display("blank done");
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_mismatch++;
         end_of_test();
      end
   end
   initial
   begin
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      test_corr();
      test_bright();
      test_blank();
      end_of_test();
   end
endmodule
bind lsspc_core lsspc_core_properties #(.CHANNELS(CHANNELS), .CORR_BITS(CORR_BITS)) u_props
   (.clk(clk), .nrst(nrst), .bright_shift_clk(bright_shift_clk),
   .bright_latch_strobe(bright_latch_strobe), .corr_shift_clk(corr_shift_clk),
   .corr_latch_strobe(corr_latch_strobe), .blank(blank), .bright_serial_out(bright_serial_out),
   .corr_serial_out(corr_serial_out), .sink_output(sink_output), .sink_level(sink_level));
